// ### fdc_dma.sv
// Purpose: four-channel dma engine mastering the system bus
// Assumes: bus slaves hold ack high for one cycle per access
// Notes: each item is a read then a write on the same bus
`timescale 1ns/1ps
module fdc_dma
  import fdc_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // software write port, shared data
  input wire logic [fdc_pkg::AW-1:0] cfg_wdata_i,
  input wire logic [fdc_pkg::NUM_CH-1:0] src_we_i,
  input wire logic [fdc_pkg::NUM_CH-1:0] pdst_we_i,
  input wire logic [fdc_pkg::NUM_CH-1:0] pcnt_we_i,
  input wire logic [fdc_pkg::NUM_CH-1:0] go_we_i,
  // channel control fields
  input wire logic [fdc_pkg::NUM_CH-1:0][fdc_pkg::MODE_W-1:0] channel_mode_field_i,
  input wire logic [fdc_pkg::NUM_CH-1:0][fdc_pkg::SIZE_W-1:0] size_field_i,
  input wire logic [fdc_pkg::NUM_CH-1:0][fdc_pkg::PS_W-1:0] peripheral_select_field_i,
  input wire logic [fdc_pkg::NUM_CH-1:0] circular_wrap_enable_i,
  input wire logic [fdc_pkg::NUM_CH-1:0] soft_request_enable_i,
  input wire logic [fdc_pkg::NUM_CH-1:0] soft_request_trigger_i,
  input wire logic [fdc_pkg::NUM_CH-1:0] source_increment_enable_i,
  input wire logic [fdc_pkg::NUM_CH-1:0] dest_increment_enable_i,
  input wire logic [fdc_pkg::NUM_CH-1:0][fdc_pkg::BW-1:0] burst_length_field_i,
  input wire logic [fdc_pkg::NUM_CH-1:0][fdc_pkg::BW-1:0] hold_length_field_i,
  // ready sources
  input wire logic mem_ready_i,
  input wire logic [fdc_pkg::NUM_CH-1:0] periph_ready_i,
  // system bus master
  input wire logic bus_gnt_i,
  input wire logic bus_ack_i,
  input wire logic [fdc_pkg::AW-1:0] bus_rdata_i,
  output logic bus_req_o,
  output logic bus_rd_o,
  output logic bus_wr_o,
  output logic [fdc_pkg::AW-1:0] bus_addr_o,
  output logic [fdc_pkg::SIZE_W-1:0] bus_size_o,
  output logic [fdc_pkg::AW-1:0] bus_wdata_o,
  output logic cpu_stall_o,
  // channel state readback
  output logic [fdc_pkg::NUM_CH-1:0] go_o,
  output logic [fdc_pkg::NUM_CH-1:0][fdc_pkg::AW-1:0] src_o,
  output logic [fdc_pkg::NUM_CH-1:0][fdc_pkg::AW-1:0] dst_o,
  output logic [fdc_pkg::NUM_CH-1:0][fdc_pkg::CW-1:0] remaining_item_count_o,
  output logic [fdc_pkg::NUM_CH-1:0][fdc_pkg::WRAP_W-1:0] wrap_reload_counter_o,
  output logic [fdc_pkg::NUM_CH-1:0] fault_o,
  output logic [fdc_pkg::NUM_CH-1:0] done_o
);
  import fdc_pkg::*;

  fdc_state_t state;
  logic [IDX_W-1:0] cur;
  logic [BW-1:0] burst_left;
  logic [BW-1:0] hold_left;

  logic [NUM_CH-1:0] ch_bad;
  logic [NUM_CH-1:0] ch_rdy;
  logic [NUM_CH-1:0] ch_elig;
  logic [NUM_CH-1:0] item_vec;
  logic any_elig;
  logic [IDX_W-1:0] pick;

  // per-channel ready, item strobe and eligibility
  for (genvar i = 0; i < NUM_CH; i++)
  begin : g_ch
    wire is_mm = (channel_mode_field_i[i] == MODE_MM);
    wire soft_rdy = soft_request_enable_i[i] && soft_request_trigger_i[i];
    wire per_rdy = periph_ready_i[peripheral_select_field_i[i]];
    // soft mode ignores the peripheral line entirely
    assign ch_rdy[i] = is_mm ? mem_ready_i :
                       (soft_request_enable_i[i] ? soft_rdy : per_rdy);
    assign ch_elig[i] = go_o[i] && !ch_bad[i] &&
                        (remaining_item_count_o[i] != CNT_ZERO) && ch_rdy[i];
    assign item_vec[i] = (state == ST_WRITE) && bus_ack_i && (cur == IDX_W'(i));

    fdc_chan u_chan
    (
      .mclk_i(mclk_i),
      .reset_i(reset_i),
      .cfg_wdata_i(cfg_wdata_i),
      .src_we_i(src_we_i[i]),
      .pdst_we_i(pdst_we_i[i]),
      .pcnt_we_i(pcnt_we_i[i]),
      .go_we_i(go_we_i[i]),
      .go_wdata_i(cfg_wdata_i[0]),
      .mode_i(channel_mode_field_i[i]),
      .size_i(size_field_i[i]),
      .circ_i(circular_wrap_enable_i[i]),
      .src_inc_i(source_increment_enable_i[i]),
      .dst_inc_i(dest_increment_enable_i[i]),
      .item_i(item_vec[i]),
      .go_o(go_o[i]),
      .src_o(src_o[i]),
      .dst_o(dst_o[i]),
      .cnt_o(remaining_item_count_o[i]),
      .wrap_o(wrap_reload_counter_o[i]),
      .fault_o(fault_o[i]),
      .done_o(done_o[i]),
      .bad_o(ch_bad[i])
    );
  end

  // fixed priority among eligible channels
  fdc_prio u_prio
  (
    .req_i(ch_elig),
    .any_o(any_elig),
    .idx_o(pick)
  );

  // fields of the channel that owns the bus
  wire [AW-1:0] cur_src = src_o[cur];
  wire [AW-1:0] cur_dst = dst_o[cur];
  wire [SIZE_W-1:0] cur_size = size_field_i[cur];
  wire cur_mm = (channel_mode_field_i[cur] == MODE_MM);
  wire cur_elig = ch_elig[cur];
  wire [BW-1:0] cur_hold = hold_length_field_i[cur];
  wire more = cur_elig && (burst_left != BL_ZERO);

  // sequencer; bus outputs are all registered
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      state <= ST_IDLE;
      cur <= '0;
      burst_left <= BL_ZERO;
      hold_left <= BL_ZERO;
      bus_req_o <= 1'b0;
      bus_rd_o <= 1'b0;
      bus_wr_o <= 1'b0;
      bus_addr_o <= ADDR_ZERO;
      bus_size_o <= SIZE_WORD;
      bus_wdata_o <= ADDR_ZERO;
      cpu_stall_o <= 1'b0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          // request stays low here, so every release lasts a cycle
          if (any_elig)
          begin
            cur <= pick;
            burst_left <= burst_length_field_i[pick];
            bus_req_o <= 1'b1;
            state <= ST_REQ;
          end
        end
        ST_REQ:
        begin
          if (!cur_elig)
          begin
            // channel stopped or ready fell before grant
            bus_req_o <= 1'b0;
            state <= ST_IDLE;
          end
          else if (bus_gnt_i)
          begin
            bus_rd_o <= 1'b1;
            bus_addr_o <= cur_src;
            bus_size_o <= cur_size;
            cpu_stall_o <= cur_mm;
            state <= ST_READ;
          end
        end
        ST_READ:
        begin
          if (bus_ack_i)
          begin
            bus_rd_o <= 1'b0;
            bus_wdata_o <= bus_rdata_i;
            bus_wr_o <= 1'b1;
            bus_addr_o <= cur_dst;
            state <= ST_WRITE;
          end
        end
        ST_WRITE:
        begin
          if (bus_ack_i)
          begin
            bus_wr_o <= 1'b0;
            state <= ST_NEXT;
          end
        end
        ST_NEXT:
        begin
          // channel counters already moved on the write ack edge
          if (more)
          begin
            burst_left <= burst_left - BL_ONE;
            bus_rd_o <= 1'b1;
            bus_addr_o <= cur_src;
            state <= ST_READ;
          end
          else
          begin
            bus_req_o <= 1'b0;
            cpu_stall_o <= 1'b0;
            hold_left <= cur_hold;
            state <= (cur_hold != BL_ZERO) ? ST_HOLD : ST_IDLE;
          end
        end
        ST_HOLD:
        begin
          // core owns the bus while we count down
          hold_left <= hold_left - BL_ONE;
          if (hold_left == BL_ONE) state <= ST_IDLE;
        end
        default:
        begin
          bus_req_o <= 1'b0;
          bus_rd_o <= 1'b0;
          bus_wr_o <= 1'b0;
          cpu_stall_o <= 1'b0;
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule : fdc_dma

// ### fdc_pkg.sv
// Purpose: constants and types shared by the four-channel dma controller
// Assumes: single 200 MHz clock, synchronous active-high reset
// Notes: fields arrive as plain ports, there is no register bus
// Operation
// - four channels, each with 32-bit source and destination pointers
// - 16-bit item count per channel, up to 64k-1 items
// - completion of a channel transfer raises its done event
// - dma keeps the bus through a whole burst once granted
// - nonzero hold count drops bus request after burst write for hold cycles
// - fixed priority, channel 0 highest, channel 3 lowest
// - software sets go to start, device clears go at completion
// - memory-to-memory mode stalls the core for each burst, max 256
// - writing go to 0 while active ends the transfer early
// - address and count stay readable, writes ignored while active
// - misaligned word or half address terminates and records a fault
// - size field picks byte, half or word for reads and writes
// - memory-to-memory starts as soon as go and ready are set
// - preload destination presets working destination, count from preload
// - 8-bit burst and hold length fields, bus released for hold states
// - peripheral select picks one of four ready sources
// - peripheral mode starts on go plus ready, soft trigger forces ready
// - circular wrap in mode 001 keeps running until go is cleared
// - separate enables for source and destination address increment
// - mode 010 is memory-to-peripheral, counted only, no wrap
// - on wrap, destination and count reload and wrap counter increments
// - ready drop ends the burst, hold, then re-request on ready
package fdc_pkg;
  localparam int NUM_CH = 4;
  localparam int IDX_W = 2;
  localparam int AW = 32;
  localparam int CW = 16;
  localparam int BW = 8;
  localparam int WRAP_W = 8;
  localparam int MODE_W = 3;
  localparam int SIZE_W = 2;
  localparam int PS_W = 2;
  localparam logic [MODE_W-1:0] MODE_MM = 3'h0;
  localparam logic [MODE_W-1:0] MODE_P2M = 3'h1;
  localparam logic [MODE_W-1:0] MODE_M2P = 3'h2;
  localparam logic [SIZE_W-1:0] SIZE_BYTE = 2'h0;
  localparam logic [SIZE_W-1:0] SIZE_HALF = 2'h1;
  localparam logic [SIZE_W-1:0] SIZE_WORD = 2'h2;
  localparam logic [AW-1:0] STEP_BYTE = 32'h1;
  localparam logic [AW-1:0] STEP_HALF = 32'h2;
  localparam logic [AW-1:0] STEP_WORD = 32'h4;
  localparam logic [AW-1:0] ADDR_ZERO = 32'h0;
  localparam logic [CW-1:0] CNT_ZERO = 16'h0;
  localparam logic [CW-1:0] CNT_ONE = 16'h1;
  localparam logic [BW-1:0] BL_ZERO = 8'h0;
  localparam logic [BW-1:0] BL_ONE = 8'h1;
  localparam logic [WRAP_W-1:0] WRAP_ZERO = 8'h0;
  localparam logic [WRAP_W-1:0] WRAP_ONE = 8'h1;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_REQ = 6'h02,
    ST_READ = 6'h04,
    ST_WRITE = 6'h08,
    ST_NEXT = 6'h10,
    ST_HOLD = 6'h20
  } fdc_state_t;
endpackage : fdc_pkg

// ### fdc_prio.sv
// Purpose: fixed priority pick among channel requests
// Assumes: requests are levels from the main engine
// Notes: purely combinational, lowest index wins
`timescale 1ns/1ps
module fdc_prio
  import fdc_pkg::*;
(
  // requests
  input wire logic [fdc_pkg::NUM_CH-1:0] req_i,
  // pick
  output logic any_o,
  output logic [fdc_pkg::IDX_W-1:0] idx_o
);
  import fdc_pkg::*;
  // scan from the highest channel down so channel 0 wins
  always_comb
  begin
    any_o = 1'b0;
    idx_o = '0;
    for (int i = NUM_CH - 1; i >= 0; i--)
    begin
      if (req_i[i])
      begin
        any_o = 1'b1;
        idx_o = IDX_W'(i);
      end
    end
  end
endmodule : fdc_prio

// ### fdc_chan.sv
// Purpose: one dma channel: pointers, count, go bit, fault, wrap counter
// Assumes: engine pulses item_i once per written item of this channel
// Notes: pointer and count writes only land while the channel is idle
`timescale 1ns/1ps
module fdc_chan
  import fdc_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  // software side
  input wire logic [fdc_pkg::AW-1:0] cfg_wdata_i,
  input wire logic src_we_i,
  input wire logic pdst_we_i,
  input wire logic pcnt_we_i,
  input wire logic go_we_i,
  input wire logic go_wdata_i,
  // static control
  input wire logic [fdc_pkg::MODE_W-1:0] mode_i,
  input wire logic [fdc_pkg::SIZE_W-1:0] size_i,
  input wire logic circ_i,
  input wire logic src_inc_i,
  input wire logic dst_inc_i,
  // engine
  input wire logic item_i,
  // state
  output logic go_o,
  output logic [fdc_pkg::AW-1:0] src_o,
  output logic [fdc_pkg::AW-1:0] dst_o,
  output logic [fdc_pkg::CW-1:0] cnt_o,
  output logic [fdc_pkg::WRAP_W-1:0] wrap_o,
  output logic fault_o,
  output logic done_o,
  output logic bad_o
);
  import fdc_pkg::*;
  logic [AW-1:0] pdst;
  logic [CW-1:0] pcnt;
  wire [AW-1:0] step = (size_i == SIZE_BYTE) ? STEP_BYTE :
                       (size_i == SIZE_HALF) ? STEP_HALF : STEP_WORD;
  wire [AW-1:0] next_src = src_inc_i ? src_o + step : src_o;
  wire [AW-1:0] next_dst = dst_inc_i ? dst_o + step : dst_o;
  wire mis_word = (size_i == SIZE_WORD) && ((|src_o[1:0]) || (|dst_o[1:0]));
  wire mis_half = (size_i == SIZE_HALF) && (src_o[0] || dst_o[0]);
  wire bad_size = (size_i != SIZE_BYTE) && (size_i != SIZE_HALF) && (size_i != SIZE_WORD);
  wire bad_mode = (mode_i != MODE_MM) && (mode_i != MODE_P2M) && (mode_i != MODE_M2P);
  wire last = (cnt_o == CNT_ONE);
  wire wrap_ok = circ_i && (mode_i == MODE_P2M);
  assign bad_o = mis_word || mis_half || bad_size || bad_mode;
  // later statements take priority: start wins over completion
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      go_o <= 1'b0;
      src_o <= ADDR_ZERO;
      dst_o <= ADDR_ZERO;
      pdst <= ADDR_ZERO;
      cnt_o <= CNT_ZERO;
      pcnt <= CNT_ZERO;
      wrap_o <= WRAP_ZERO;
      fault_o <= 1'b0;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      if (src_we_i && !go_o) src_o <= cfg_wdata_i;
      if (pdst_we_i && !go_o)
      begin
        pdst <= cfg_wdata_i;
        dst_o <= cfg_wdata_i;
      end
      if (pcnt_we_i && !go_o) pcnt <= cfg_wdata_i[CW-1:0];
      if (go_we_i && !go_wdata_i) go_o <= 1'b0;
      if (item_i)
      begin
        src_o <= next_src;
        dst_o <= next_dst;
        cnt_o <= cnt_o - CNT_ONE;
        if (last && wrap_ok)
        begin
          dst_o <= pdst;
          cnt_o <= pcnt;
          wrap_o <= wrap_o + WRAP_ONE;
        end
        // an item that lands after a software stop must not pulse done
        else if (last && go_o)
        begin
          go_o <= 1'b0;
          done_o <= 1'b1;
        end
      end
      // empty count finishes at once
      if (go_o && !item_i && !bad_o && cnt_o == CNT_ZERO)
      begin
        go_o <= 1'b0;
        done_o <= 1'b1;
      end
      if (go_o && bad_o)
      begin
        go_o <= 1'b0;
        fault_o <= 1'b1;
      end
      if (go_we_i && go_wdata_i && !go_o)
      begin
        go_o <= 1'b1;
        cnt_o <= pcnt;
        fault_o <= 1'b0;
      end
    end
  end
endmodule : fdc_chan

// ### fdc_assertions.sv
// Purpose: port checks on the dma engine
// Assumes: one clock, synchronous reset
// Notes: bound to every fdc_dma instance
`timescale 1ns/1ps
module fdc_chk
  import fdc_pkg::*;
(
  // clock, reset, software
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [fdc_pkg::AW-1:0] cfg_wdata_i,
  input wire logic [fdc_pkg::NUM_CH-1:0] go_we_i,
  // bus and channel state
  input wire logic bus_ack_i,
  input wire logic [fdc_pkg::AW-1:0] bus_rdata_i,
  input wire logic bus_req_o,
  input wire logic bus_rd_o,
  input wire logic bus_wr_o,
  input wire logic [fdc_pkg::AW-1:0] bus_wdata_o,
  input wire logic cpu_stall_o,
  input wire logic [fdc_pkg::NUM_CH-1:0] go_o,
  input wire logic [fdc_pkg::NUM_CH-1:0] fault_o,
  input wire logic [fdc_pkg::NUM_CH-1:0] done_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);
  // bus strobes stand until acked, read always precedes write
  rd_hold_a: assert property (bus_rd_o && !bus_ack_i |=> bus_rd_o)
    else $error("read strobe dropped before ack");
  rd_to_wr_a: assert property (bus_rd_o && bus_ack_i |=> bus_wr_o && !bus_rd_o && bus_wdata_o == $past(bus_rdata_i))
    else $error("write does not carry the read data");
  wr_hold_a: assert property (bus_wr_o && !bus_ack_i |=> bus_wr_o && !bus_rd_o)
    else $error("write strobe dropped before ack");
  bus_owned_a: assert property ((bus_rd_o || bus_wr_o) |-> bus_req_o)
    else $error("access without bus request");
  stall_burst_a: assert property (cpu_stall_o |-> bus_req_o)
    else $error("core stalled outside a burst");
  // completion pulse comes with the automatic clear of go
  done_go_a: assert property (done_o != 4'h0 |-> (done_o & go_o) == 4'h0 && (done_o & $past(go_o)) == done_o)
    else $error("done without go clearing");
  fault_stop_a: assert property ((fault_o & ~$past(fault_o)) != 4'h0 |-> (fault_o & ~$past(fault_o) & go_o) == 4'h0)
    else $error("fault left channel running");
  go_start_a: assert property (go_we_i[0] && cfg_wdata_i[0] |=> go_o[0])
    else $error("go write did not set go");
  req_go_a: assert property ($rose(bus_req_o) |-> go_o != 4'h0)
    else $error("bus request with no channel started");
  cover property (done_o != 4'h0);
  cover property ($rose(fault_o[3]));
  cover property ($fell(bus_req_o) ##1 !bus_req_o ##1 !bus_req_o ##1 bus_req_o);
endmodule : fdc_chk
bind fdc_dma fdc_chk u_chk (.mclk_i, .reset_i, .cfg_wdata_i, .go_we_i, .bus_ack_i, .bus_rdata_i,
  .bus_req_o, .bus_rd_o, .bus_wr_o, .bus_wdata_o, .cpu_stall_o, .go_o, .fault_o, .done_o);

// ### fdc_bus_model.sv
// Purpose: far-side bus slave for the dma engine
// Assumes: one clock, synchronous reset
// Notes: stall_i delays grant and ack at random
`timescale 1ns/1ps
module fdc_bus_model
  import fdc_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // master requests
  input wire logic req_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [fdc_pkg::AW-1:0] addr_i,
  input wire logic stall_i,
  // slave answers
  output logic gnt_o,
  output logic ack_o,
  output logic [fdc_pkg::AW-1:0] rdata_o
);
  logic gnt_held;
  // once granted the bus stays with the dma until it lets go
  assign gnt_o = req_i && (gnt_held || !stall_i);
  // one-cycle ack; data line toggles when not answering
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      gnt_held <= 1'b0;
      ack_o <= 1'b0;
      rdata_o <= 32'h0;
    end
    else
    begin
      gnt_held <= gnt_o;
      ack_o <= (rd_i || wr_i) && !ack_o && !stall_i;
      rdata_o <= (rd_i && !ack_o && !stall_i) ? {addr_i[15:0] ^ 16'hC3C3, addr_i[15:0]} : ~rdata_o;
    end
  end
endmodule : fdc_bus_model

// ### fdc_dma_tb_top.sv
// Purpose: self-checking bench for the dma engine
// Assumes: 200 MHz clock, synchronous reset
// Notes: acked writes are matched against a queue
`timescale 1ns/1ps
module fdc_dma_tb_top;
  import fdc_pkg::*;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [AW-1:0] cfg_wdata_i = 32'h0;
  logic [NUM_CH-1:0] src_we_i = 4'h0, pdst_we_i = 4'h0, pcnt_we_i = 4'h0, go_we_i = 4'h0;
  logic [NUM_CH-1:0][MODE_W-1:0] channel_mode_field_i = 12'h0;
  logic [NUM_CH-1:0][SIZE_W-1:0] size_field_i = 8'hAA;
  logic [NUM_CH-1:0][PS_W-1:0] peripheral_select_field_i = 8'h0;
  logic [NUM_CH-1:0] circular_wrap_enable_i = 4'h0, soft_request_enable_i = 4'h0, soft_request_trigger_i = 4'h0;
  logic [NUM_CH-1:0] source_increment_enable_i = 4'hF, dest_increment_enable_i = 4'hF;
  logic [NUM_CH-1:0][BW-1:0] burst_length_field_i = 32'h0, hold_length_field_i = 32'h0;
  logic mem_ready_i = 1'b1;
  logic [NUM_CH-1:0] periph_ready_i = 4'h0;
  logic bus_stall = 1'b0;
  wire logic bus_gnt_i, bus_ack_i, bus_req_o, bus_rd_o, bus_wr_o, cpu_stall_o;
  wire logic [AW-1:0] bus_rdata_i, bus_addr_o, bus_wdata_o;
  wire logic [SIZE_W-1:0] bus_size_o;
  wire logic [NUM_CH-1:0] go_o, fault_o, done_o;
  wire logic [NUM_CH-1:0][AW-1:0] src_o, dst_o;
  wire logic [NUM_CH-1:0][CW-1:0] remaining_item_count_o;
  wire logic [NUM_CH-1:0][WRAP_W-1:0] wrap_reload_counter_o;
  int err_total = 0, n_checks = 0, n_done = 0, n = 0;
  integer seed = 32'h2A54;
  logic [63:0] q[$];
  logic [AW-1:0] s;
  // expected {bus size, core stall} on every acked write
  logic [SIZE_W:0] exp_ctl = {SIZE_WORD, 1'b1};
  fdc_dma u_dut (.mclk_i, .reset_i, .cfg_wdata_i, .src_we_i, .pdst_we_i, .pcnt_we_i, .go_we_i,
    .channel_mode_field_i, .size_field_i, .peripheral_select_field_i, .circular_wrap_enable_i,
    .soft_request_enable_i, .soft_request_trigger_i, .source_increment_enable_i,
    .dest_increment_enable_i, .burst_length_field_i, .hold_length_field_i, .mem_ready_i,
    .periph_ready_i, .bus_gnt_i, .bus_ack_i, .bus_rdata_i, .bus_req_o, .bus_rd_o, .bus_wr_o,
    .bus_addr_o, .bus_size_o, .bus_wdata_o, .cpu_stall_o, .go_o, .src_o, .dst_o,
    .remaining_item_count_o, .wrap_reload_counter_o, .fault_o, .done_o);
  fdc_bus_model u_bus (.mclk_i, .reset_i, .req_i(bus_req_o), .rd_i(bus_rd_o), .wr_i(bus_wr_o),
    .addr_i(bus_addr_o), .stall_i(bus_stall), .gnt_o(bus_gnt_i), .ack_o(bus_ack_i), .rdata_o(bus_rdata_i));
  initial
    forever #2.5 mclk_i = ~mclk_i;
  // random slowness of the far side
  always @(posedge mclk_i)
    bus_stall <= ($random(seed) & 3) == 0;
  // independent copy of the slave data pattern
  function automatic logic [AW-1:0] rd_val(input logic [AW-1:0] a);
    return {a[15:0] ^ 16'hC3C3, a[15:0]};
  endfunction : rd_val
  task automatic chk(input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  // k picks source, dest, count or go; idle cycle after so strobes never collide
  task automatic wr_cfg(input logic [3:0] m, input int k, input logic [AW-1:0] v);
    cfg_wdata_i <= v;
    {go_we_i, pcnt_we_i, pdst_we_i, src_we_i} <= 16'(m) << (4 * k);
    @(posedge mclk_i);
    {go_we_i, pcnt_we_i, pdst_we_i, src_we_i} <= 16'h0;
    @(posedge mclk_i);
  endtask : wr_cfg
  task automatic wait_req(input logic v);
    n = 0;
    while (bus_req_o !== v && n < 3000)
    begin
      @(posedge mclk_i);
      n++;
    end
    if (n >= 3000) err_total++;
  endtask : wait_req
  task automatic print_verdict();
    if (err_total == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  // oldest expected write against each acked write
  always @(posedge mclk_i)
  begin
    n_done += $countones(done_o);
    if (bus_wr_o && bus_ack_i)
    begin
      chk(q.size() ? q.pop_front() : 64'h0, {bus_addr_o, bus_wdata_o});
      chk(64'(exp_ctl), 64'({bus_size_o, cpu_stall_o}));
    end
  end
  initial
  begin
    repeat (20000) @(posedge mclk_i);
    err_total++;
    print_verdict();
  end
  initial
  begin
    repeat (20) @(posedge mclk_i);
    reset_i <= 1'b0;
    @(posedge mclk_i);
    // counted copy, two-item bursts, two hold cycles
    s = $random(seed) & 32'hFFFC;
    burst_length_field_i[0] <= 8'h01;
    hold_length_field_i[0] <= 8'h02;
    wr_cfg(4'h1, 0, s);
    wr_cfg(4'h1, 1, 32'h4000);
    wr_cfg(4'h1, 2, 32'h3);
    for (int i = 0; i < 3; i++)
      q.push_back({32'h4000 + 4 * i, rd_val(s + 4 * i)});
    wr_cfg(4'h1, 3, 32'h1);
    wr_cfg(4'h1, 0, 32'hDEADBEE0);
    wait_req(1'b1);
    wait_req(1'b0);
    wait_req(1'b1);
    chk(64'h3, 64'(n));
    wait_go_0: for (int i = 0; i < 3000 && go_o[0] !== 1'b0; i++)
      @(posedge mclk_i);
    chk({CNT_ZERO, s + 32'hC}, {remaining_item_count_o[0], src_o[0]});
    chk(64'h400C, 64'(dst_o[0]));
    // two peripheral channels started together, lower index served first
    channel_mode_field_i <= {MODE_MM, MODE_M2P, MODE_P2M, MODE_MM};
    circular_wrap_enable_i <= 4'h4;
    exp_ctl <= {SIZE_WORD, 1'b0};
    peripheral_select_field_i <= 8'h08;
    periph_ready_i <= 4'h4;
    soft_request_enable_i <= 4'h4;
    soft_request_trigger_i <= 4'h4;
    dest_increment_enable_i <= 4'hB;
    burst_length_field_i <= 32'h0;
    wr_cfg(4'h6, 0, s);
    wr_cfg(4'h2, 1, 32'h5000);
    wr_cfg(4'h4, 1, 32'h6000);
    wr_cfg(4'h6, 2, 32'h2);
    for (int i = 0; i < 2; i++)
      q.push_back({32'h5000 + 4 * i, rd_val(s + 4 * i)});
    for (int i = 0; i < 2; i++)
      q.push_back({32'h6000, rd_val(s + 4 * i)});
    wr_cfg(4'h6, 3, 32'h1);
    wait_go_12: for (int i = 0; i < 3000 && go_o[2:1] !== 2'h0; i++)
      @(posedge mclk_i);
    // misaligned half, misaligned word, bad mode, bad size
    for (int i = 0; i < 4; i++)
    begin
      channel_mode_field_i[3] <= (i == 2) ? 3'h5 : MODE_MM;
      size_field_i[3] <= (i == 3) ? 2'h3 : (i == 0) ? SIZE_HALF : SIZE_WORD;
      wr_cfg(4'h8, 0, (i == 0) ? 32'h101 : 32'h100);
      wr_cfg(4'h8, 1, (i == 1) ? 32'h202 : 32'h200);
      wr_cfg(4'h8, 2, 32'h1);
      wr_cfg(4'h8, 3, 32'h1);
      @(posedge mclk_i);
      chk(64'h8, {go_o, fault_o});
    end
    // circular byte capture, stopped by software after one wrap
    channel_mode_field_i[0] <= MODE_P2M;
    size_field_i[0] <= SIZE_BYTE;
    exp_ctl <= {SIZE_BYTE, 1'b0};
    circular_wrap_enable_i <= 4'h1;
    soft_request_enable_i <= 4'h1;
    soft_request_trigger_i <= 4'h1;
    burst_length_field_i[0] <= 8'h01;
    wr_cfg(4'h1, 0, s | 32'h1);
    wr_cfg(4'h1, 1, 32'h7001);
    wr_cfg(4'h1, 2, 32'h2);
    for (int i = 0; i < 2; i++)
      q.push_back({32'h7001 + i, rd_val((s | 32'h1) + i)});
    wr_cfg(4'h1, 3, 32'h1);
    wait_wrap: for (int i = 0; i < 3000 && wrap_reload_counter_o[0] !== WRAP_ONE; i++)
      @(posedge mclk_i);
    soft_request_trigger_i <= 4'h0;
    repeat (10) @(posedge mclk_i);
    chk({32'h7001, 16'h2, WRAP_ONE, 8'h1}, {dst_o[0], remaining_item_count_o[0], wrap_reload_counter_o[0], 7'h0, go_o[0]});
    chk(64'h3, 64'(n_done));
    wr_cfg(4'h1, 3, 32'h0);
    chk(64'h0, 64'(go_o));
    chk(64'h0, 64'(q.size()));
    print_verdict();
  end
endmodule : fdc_dma_tb_top
